// ===== rtl/scp_pkg.sv
// Shared constants, field positions and helper functions for the serial configuration port.
`default_nettype none
package scp_pkg;

  // Device register file geometry.
  localparam int unsigned REG_COUNT  = 32;  // Registers reachable by the 5-bit header address.
  localparam int unsigned ADDR_W     = 5;   // Header address width.
  localparam int unsigned DATA_W     = 8;   // Register width.

  // Port options register and its fields.
  localparam logic [4:0] OPT_ADDR      = 5'h00;  // Offset of serial_port_options.
  localparam int unsigned OPT_FOUR_BIT = 7;      // Four-wire enable.
  localparam int unsigned OPT_LSB_BIT  = 6;      // Least-significant-bit-first enable.
  localparam logic [7:0] REG_RESET     = 8'h00;  // Reset value of every register.

  // Instruction header fields, as assembled in natural bit order.
  localparam int unsigned HDR_RW_BIT   = 7;      // One requests a read.
  localparam int unsigned HDR_CNT_HI   = 6;      // byte_count_high.
  localparam int unsigned HDR_CNT_LO   = 5;      // byte_count_low.
  localparam int unsigned HDR_ADDR_HI  = 4;      // reg_address_msb; reg_address_lsb is bit 0.
  localparam logic [2:0] BIT_LAST      = 3'h7;   // Index of the eighth bit of a byte.

  // Controller register map on the Wishbone side (byte addresses).
  localparam logic [7:0] WB_CTRL = 8'h00;  // Command: start, direction, count, address.
  localparam logic [7:0] WB_TXD  = 8'h04;  // Write data, first byte in bits 7:0.
  localparam logic [7:0] WB_RXD  = 8'h08;  // Read data, first byte in bits 7:0.
  localparam logic [7:0] WB_STAT = 8'h0c;  // Busy and sticky done.
  localparam logic [7:0] WB_MODE = 8'h10;  // Link mode mirror: four-wire and bit order.

  // Controller field positions.
  localparam int unsigned CTRL_GO     = 0;
  localparam int unsigned CTRL_READ   = 1;
  localparam int unsigned CTRL_CNT_LO = 2;  // Two bits: byte count minus one.
  localparam int unsigned CTRL_ADR_LO = 4;  // Five bits: header address.
  localparam int unsigned STAT_BUSY   = 0;
  localparam int unsigned STAT_DONE   = 1;
  localparam int unsigned MODE_FOUR   = 0;
  localparam int unsigned MODE_LSB    = 1;

  // Serial clock timing made by the controller.
  localparam int unsigned CLK_PERIOD_NS  = 5;   // System clock period.
  localparam int unsigned SCLK_PERIOD_NS = 80;  // Serial clock period.
  localparam int unsigned SCLK_HALF_CYC  = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);

  // Shift one received bit into a byte in the selected order.
  function automatic logic [7:0] shift_in(input logic [7:0] v, input logic b,
                                          input logic lsb);
    return lsb ? {b, v[7:1]} : {v[6:0], b};
  endfunction

  // Pick the bit sent at position i of a byte in the selected order.
  function automatic logic pick_bit(input logic [7:0] v, input logic [2:0] i,
                                    input logic lsb);
    return lsb ? v[i] : v[BIT_LAST - i];
  endfunction

endpackage
`default_nettype wire

// ===== rtl/scp_if.sv
// Serial link between the controller and the configuration port, with wire resolution.
`timescale 1ns/1ps
`default_nettype none
interface scp_if;
  logic sclk;          // Serial clock, made by the controller.
  logic serial_select_n;  // Active-low transfer enable.
  logic sdio_host;     // Controller drive value on the data pin.
  logic sdio_host_oe;  // Controller drives the data pin.
  logic sdio_dev;      // Device drive value on the data pin.
  logic sdio_dev_oe;   // Device drives the data pin.
  logic sout_dev;         // Device drive value on serial_data_out.
  logic sout_dev_oe;      // Device drives serial_data_out.
  logic sdio_line;        // Resolved data pin level, pulled high when idle.
  logic serial_data_out;  // Resolved output pin level, pulled high when idle.

  // Wire levels; an undriven pin floats high through a pull-up.
  assign sdio_line       = sdio_host_oe ? sdio_host : (sdio_dev_oe ? sdio_dev : 1'b1);
  assign serial_data_out = sout_dev_oe ? sout_dev : 1'b1;

  modport device (input sclk, input serial_select_n, input sdio_line,
                  output sdio_dev, output sdio_dev_oe, output sout_dev, output sout_dev_oe);
  modport host (output sclk, output serial_select_n, output sdio_host, output sdio_host_oe,
                input sdio_line, input serial_data_out);
endinterface
`default_nettype wire

// ===== rtl/scp_device.sv
// Configuration port end: serial slave with its register file.
// Notes on behaviour
// R1: Default three-wire port, one bidirectional data pin.
// R2: Enable high releases both data pins.
// R3: Options bit 7 moves read data to output.
// R4: Output pin driven only while shifting read data.
// R5: Three-wire mode never drives the output pin.
// R6: Four-wire read never drives the data pin.
// R7: Master opens each transfer with instruction byte.
// R8: First header bit: one reads, zero writes.
// R9: Next two bits give one to four bytes.
// R10: Five address bits; data follows without gap.
// R11: Options bit 6 orders bits, resets MSB-first.
// R12: MSB-first multibyte steps address downward.
// R13: LSB-first shifts header and data LSB first.
// R14: LSB-first multibyte steps address upward.
// R15: Header sampled on rising clock after enable falls.
// R16: Write bytes captured on rising edges, count times.
// R17: Master holds enable low until last bit.
// R18: Read bits driven on falling edges, address steps.
// R19: Master writes zero to undefined bits.
// R20: Enable rising early abandons transfer, clears counters.
`timescale 1ns/1ps
`default_nettype none
module scp_device #(
  parameter int unsigned REG_COUNT = scp_pkg::REG_COUNT
) (
  // Clock and reset.
  input  wire logic       clk_i,
  input  wire logic       rstn_i,
  // Serial link.
  scp_if.device           link,
  // User side: current options and a notice of each register write.
  output logic            cfg_four_wire_o,
  output logic            cfg_lsb_first_o,
  output logic            wr_stb_o,
  output logic [4:0]      wr_addr_o,
  output logic [7:0]      wr_data_o
);

  // Transfer phases; a high enable always returns to the header phase.
  typedef enum logic [1:0] {ST_HEAD, ST_WRITE, ST_READ, ST_DONE} scp_dev_state_t;

  // Register file; entry zero holds the port options.
  logic [7:0]     regs_reg [REG_COUNT];

  // Synchronisers; stage one feeds stage two only, stage three is an edge delay.
  logic           sclk_s1_reg, sclk_s2_reg, sclk_s3_reg;
  logic           sel_s1_reg, sel_s2_reg;
  logic           sdio_s1_reg, sdio_s2_reg;

  // Transfer state.
  scp_dev_state_t state_reg;
  logic [2:0]     bit_cnt_reg;    // Bit within the current byte.
  logic [1:0]     byte_cnt_reg;   // Byte within the transfer.
  logic [1:0]     byte_last_reg;  // Encoded byte count minus one.
  logic [4:0]     addr_reg;       // Register being accessed.
  logic [7:0]     shift_reg;      // Incoming header or write byte.
  logic           fin_reg;        // Last read bit has been driven.

  // Pin drive registers.
  logic           dout_reg;
  logic           sdio_oe_reg;
  logic           sout_oe_reg;

  // Decoded events and live option bits.
  logic           sclk_rise, sclk_fall, sel_active;
  logic           four_wire, lsb_first;
  logic [7:0]     byte_in;
  logic [4:0]     addr_step;
  logic           wr_evt;

  assign sclk_rise  = sclk_s2_reg & ~sclk_s3_reg;
  assign sclk_fall  = ~sclk_s2_reg & sclk_s3_reg;
  assign sel_active = ~sel_s2_reg;
  assign four_wire  = regs_reg[scp_pkg::OPT_ADDR][scp_pkg::OPT_FOUR_BIT];  // [R3]
  assign lsb_first  = regs_reg[scp_pkg::OPT_ADDR][scp_pkg::OPT_LSB_BIT];   // [R13]
  // Order applies to header and data alike.
  assign byte_in    = scp_pkg::shift_in(shift_reg, sdio_s2_reg, lsb_first);  // [R13]
  // Upward in LSB-first order, downward otherwise.
  assign addr_step  = lsb_first ? addr_reg + 5'h01 : addr_reg - 5'h01;  // [R12] [R14]
  // A write lands when the eighth data bit of a byte is sampled.
  assign wr_evt = sel_active && (state_reg == ST_WRITE) && sclk_rise
                  && (bit_cnt_reg == scp_pkg::BIT_LAST);  // [R16]

  // Every pin from the link is re-timed by two flip-flops before use.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sclk_s1_reg <= 1'b0;
      sclk_s2_reg <= 1'b0;
      sclk_s3_reg <= 1'b0;
      sel_s1_reg  <= 1'b1;
      sel_s2_reg  <= 1'b1;
      sdio_s1_reg <= 1'b1;
      sdio_s2_reg <= 1'b1;
    end else begin
      sclk_s1_reg <= link.sclk;
      sclk_s2_reg <= sclk_s1_reg;
      sclk_s3_reg <= sclk_s2_reg;
      sel_s1_reg  <= link.serial_select_n;
      sel_s2_reg  <= sel_s1_reg;
      sdio_s1_reg <= link.sdio_line;
      sdio_s2_reg <= sdio_s1_reg;
    end
  end

  // Transfer sequencer: header, then write or read bytes, then wait for release.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_reg     <= ST_HEAD;
      bit_cnt_reg   <= 3'h0;
      byte_cnt_reg  <= 2'h0;
      byte_last_reg <= 2'h0;
      addr_reg      <= 5'h00;
      shift_reg     <= 8'h00;
      fin_reg       <= 1'b0;
    end else if (!sel_active) begin
      // A high enable ends or abandons any transfer and clears the counters.
      state_reg    <= ST_HEAD;  // [R20]
      bit_cnt_reg  <= 3'h0;     // [R20]
      byte_cnt_reg <= 2'h0;     // [R20]
      fin_reg      <= 1'b0;
    end else begin
      unique case (state_reg)
        ST_HEAD: begin
          // Header bits are sampled on rising serial clock edges.
          if (sclk_rise) begin  // [R15]
            shift_reg   <= byte_in;
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            if (bit_cnt_reg == scp_pkg::BIT_LAST) begin
              // Decode direction, length and address; data follows at once.
              byte_last_reg <= byte_in[scp_pkg::HDR_CNT_HI:scp_pkg::HDR_CNT_LO];  // [R9]
              addr_reg      <= byte_in[scp_pkg::HDR_ADDR_HI:0];  // [R10]
              byte_cnt_reg  <= 2'h0;
              state_reg <= byte_in[scp_pkg::HDR_RW_BIT] ? ST_READ : ST_WRITE;  // [R8]
            end
          end
        end
        ST_WRITE: begin
          // Eight bits per register on rising edges, repeated per byte.
          if (sclk_rise) begin  // [R16]
            shift_reg   <= byte_in;
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            if (bit_cnt_reg == scp_pkg::BIT_LAST) begin
              addr_reg <= addr_step;  // [R12] [R14]
              if (byte_cnt_reg == byte_last_reg) begin
                state_reg <= ST_DONE;
              end else begin
                byte_cnt_reg <= byte_cnt_reg + 2'h1;
              end
            end
          end
        end
        ST_READ: begin
          // Bits leave on falling edges; one more falling edge ends the drive.
          if (sclk_fall) begin  // [R18]
            if (fin_reg) begin
              state_reg <= ST_DONE;
            end else begin
              bit_cnt_reg <= bit_cnt_reg + 3'h1;
              if (bit_cnt_reg == scp_pkg::BIT_LAST) begin
                if (byte_cnt_reg == byte_last_reg) begin
                  fin_reg <= 1'b1;
                end else begin
                  addr_reg     <= addr_step;  // [R18]
                  byte_cnt_reg <= byte_cnt_reg + 2'h1;
                end
              end
            end
          end
        end
        ST_DONE: begin
          // Extra clocks are ignored until the enable rises.
          state_reg <= ST_DONE;
        end
      endcase
    end
  end

  // Register file; a write to the options entry changes the port mode at once.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        regs_reg[i] <= scp_pkg::REG_RESET;  // [R11]
      end
    end else if (wr_evt) begin
      regs_reg[addr_reg] <= byte_in;  // [R16]
    end
  end

  // Write notice to user logic, one clock per completed register write.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wr_stb_o  <= 1'b0;
      wr_addr_o <= 5'h00;
      wr_data_o <= 8'h00;
    end else begin
      wr_stb_o <= wr_evt;
      if (wr_evt) begin
        wr_addr_o <= addr_reg;
        wr_data_o <= byte_in;
      end
    end
  end

  // Pin drivers. Only one pin is ever enabled, chosen by the live mode bit,
  // so toggling the mode in mid-read moves the data to the other pin.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      dout_reg    <= 1'b1;
      sdio_oe_reg <= 1'b0;
      sout_oe_reg <= 1'b0;
    end else if (!sel_active || state_reg != ST_READ) begin
      // Released while idle, during header and writes, and after a read.
      sdio_oe_reg <= 1'b0;  // [R2] [R1]
      sout_oe_reg <= 1'b0;  // [R2] [R4]
    end else if (sclk_fall) begin
      if (fin_reg) begin
        sdio_oe_reg <= 1'b0;
        sout_oe_reg <= 1'b0;  // [R4]
      end else begin
        dout_reg    <= scp_pkg::pick_bit(regs_reg[addr_reg], bit_cnt_reg, lsb_first);  // [R18]
        sdio_oe_reg <= ~four_wire;  // [R6] [R1]
        sout_oe_reg <= four_wire;   // [R3] [R5]
      end
    end
  end

  assign link.sdio_dev    = dout_reg;
  assign link.sdio_dev_oe = sdio_oe_reg;
  assign link.sout_dev    = dout_reg;
  assign link.sout_dev_oe = sout_oe_reg;
  assign cfg_four_wire_o  = four_wire;
  assign cfg_lsb_first_o  = lsb_first;

endmodule
`default_nettype wire

// ===== rtl/scp_host.sv
// Controller end: Wishbone registers driving the serial master.
`timescale 1ns/1ps
`default_nettype none
module scp_host #(
  parameter int unsigned HALF_CYC = scp_pkg::SCLK_HALF_CYC
) (
  // Clock and reset.
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  // Wishbone classic slave.
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // Serial link.
  scp_if.host              link
);

  // Link phases: clock low, clock high, enable tail, enable-high gap.
  typedef enum logic [2:0] {ST_IDLE, ST_LOW, ST_HIGH, ST_TAIL, ST_GAP} scp_host_state_t;

  localparam logic [7:0] HALF_LAST = 8'(HALF_CYC - 1);

  scp_host_state_t state_reg;
  logic [7:0]  div_reg;               // Half-period counter.
  logic [2:0]  bit_reg, byte_reg;     // Bit in byte; byte 0 is the header.
  logic [7:0]  rx_sr_reg;
  logic [31:0] rxd_reg, txd_reg;
  logic        rd_reg, start_reg, done_reg;
  logic [1:0]  cnt_reg, mode_reg;
  logic [4:0]  adr_reg;
  logic        sclk_reg, sel_n_reg, dout_reg, oe_reg;
  logic        sdio_s1_reg, sdio_s2_reg, sout_s1_reg, sout_s2_reg;

  logic        req, wr_hit, half_end, last_bit, done_evt, lsb, din;
  logic [2:0]  nbyte;
  logic [2:0]  nbit;
  logic [7:0]  rx_next;

  assign req      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  // A write commits at the edge where the master sees ack high, never earlier.
  assign wr_hit   = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
  assign half_end = (div_reg == HALF_LAST);
  assign lsb      = mode_reg[scp_pkg::MODE_LSB];
  assign din      = mode_reg[scp_pkg::MODE_FOUR] ? sout_s2_reg : sdio_s2_reg;
  assign last_bit = (bit_reg == scp_pkg::BIT_LAST) && (byte_reg == {1'b0, cnt_reg} + 3'h1);
  assign nbit     = bit_reg + 3'h1;
  assign nbyte    = (bit_reg == scp_pkg::BIT_LAST) ? byte_reg + 3'h1 : byte_reg;
  assign done_evt = (state_reg == ST_GAP) && half_end;
  assign rx_next  = scp_pkg::shift_in(rx_sr_reg, din, lsb);

  // Byte sent in a slot: the header first, then write data from the low byte up.
  function automatic logic [7:0] tx_byte(input logic [2:0] idx);
    logic [1:0] d;
    d = 2'(idx - 3'h1);
    return (idx == 3'h0) ? {rd_reg, cnt_reg, adr_reg} : txd_reg[{d, 3'b000} +: 8];
  endfunction

  // Read-back pins are re-timed before sampling.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sdio_s1_reg <= 1'b1;
      sdio_s2_reg <= 1'b1;
      sout_s1_reg <= 1'b1;
      sout_s2_reg <= 1'b1;
    end else begin
      sdio_s1_reg <= link.sdio_line;
      sdio_s2_reg <= sdio_s1_reg;
      sout_s1_reg <= link.serial_data_out;
      sout_s2_reg <= sout_s1_reg;
    end
  end

  // Wishbone slave: answer every request one clock later, unmapped reads give zero.
  // Writes land in the ack cycle, so a master that waits for ack sees them applied.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wb_ack_o  <= 1'b0;
      wb_dat_o  <= 32'h0000_0000;
      txd_reg   <= 32'h0000_0000;
      mode_reg  <= 2'h0;
      rd_reg    <= 1'b0;
      cnt_reg   <= 2'h0;
      adr_reg   <= 5'h00;
      start_reg <= 1'b0;
      done_reg  <= 1'b0;
    end else begin
      wb_ack_o  <= req;
      start_reg <= 1'b0;
      // Done is sticky; a new completion wins over a clear in the same clock.
      done_reg  <= (done_reg & ~(wr_hit & (wb_adr_i == scp_pkg::WB_STAT)
                  & wb_dat_i[scp_pkg::STAT_DONE])) | done_evt;
      if (wr_hit) begin
        unique case (wb_adr_i)
          scp_pkg::WB_CTRL: begin
            // A command while busy is dropped; it would corrupt the header.
            if (state_reg == ST_IDLE && wb_dat_i[scp_pkg::CTRL_GO]) begin
              rd_reg    <= wb_dat_i[scp_pkg::CTRL_READ];
              cnt_reg   <= wb_dat_i[scp_pkg::CTRL_CNT_LO +: 2];
              adr_reg   <= wb_dat_i[scp_pkg::CTRL_ADR_LO +: 5];
              start_reg <= 1'b1;
            end
          end
          scp_pkg::WB_TXD: begin
            for (int i = 0; i < 4; i++) begin
              if (wb_sel_i[i]) txd_reg[i*8 +: 8] <= wb_dat_i[i*8 +: 8];
            end
          end
          scp_pkg::WB_MODE: mode_reg <= wb_dat_i[1:0];
          default: ;
        endcase
      end
      if (req && !wb_we_i) begin
        unique case (wb_adr_i)
          scp_pkg::WB_TXD:  wb_dat_o <= txd_reg;
          scp_pkg::WB_RXD:  wb_dat_o <= rxd_reg;
          scp_pkg::WB_STAT: wb_dat_o <= {30'h0, done_reg, state_reg != ST_IDLE};
          scp_pkg::WB_MODE: wb_dat_o <= {30'h0, mode_reg};
          default:          wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Serial master: drive on the low phase, device samples on the rising edge.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_reg <= ST_IDLE;
      div_reg   <= 8'h00;
      bit_reg   <= 3'h0;
      byte_reg  <= 3'h0;
      rx_sr_reg <= 8'h00;
      rxd_reg   <= 32'h0000_0000;
      sclk_reg  <= 1'b0;
      sel_n_reg <= 1'b1;
      dout_reg  <= 1'b1;
      oe_reg    <= 1'b0;
    end else begin
      div_reg <= (state_reg == ST_IDLE || half_end) ? 8'h00 : div_reg + 8'h01;
      unique case (state_reg)
        ST_IDLE: begin
          if (start_reg) begin
            // Header goes first.
            sel_n_reg <= 1'b0;
            bit_reg   <= 3'h0;
            byte_reg  <= 3'h0;
            dout_reg  <= scp_pkg::pick_bit(tx_byte(3'h0), 3'h0, lsb);  // [R7]
            oe_reg    <= 1'b1;
            state_reg <= ST_LOW;
          end
        end
        ST_LOW: begin
          if (half_end) begin
            sclk_reg <= 1'b1;
            // Read data is taken just before the rising edge.
            if (rd_reg && byte_reg != 3'h0) begin
              rx_sr_reg <= rx_next;
              if (bit_reg == scp_pkg::BIT_LAST) begin
                rxd_reg[{2'(byte_reg - 3'h1), 3'b000} +: 8] <= rx_next;
              end
            end
            state_reg <= ST_HIGH;
          end
        end
        ST_HIGH: begin
          if (half_end) begin
            sclk_reg <= 1'b0;
            if (last_bit) begin
              oe_reg    <= 1'b0;
              state_reg <= ST_TAIL;
            end else begin
              // Data follows the header with no gap.
              bit_reg   <= nbit;
              byte_reg  <= nbyte;
              dout_reg  <= scp_pkg::pick_bit(tx_byte(nbyte), nbit, lsb);  // [R10]
              oe_reg    <= ~(rd_reg && nbyte != 3'h0);  // [R6]
              state_reg <= ST_LOW;
            end
          end
        end
        ST_TAIL: begin
          // Enable is released only after the last bit is clocked.
          if (half_end) begin
            sel_n_reg <= 1'b1;  // [R17]
            state_reg <= ST_GAP;
          end
        end
        ST_GAP: begin
          if (half_end) state_reg <= ST_IDLE;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  assign link.sclk            = sclk_reg;
  assign link.serial_select_n = sel_n_reg;
  assign link.sdio_host       = dout_reg;
  assign link.sdio_host_oe    = oe_reg;

endmodule
`default_nettype wire

// ===== testbench/scp_link_props.sv
// Checker for the serial link between the controller and the configuration port.
`timescale 1ns/1ps
`default_nettype none
module scp_link_props (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rstn_i,
  // Link signals.
  input wire logic sclk,
  input wire logic serial_select_n,
  input wire logic sdio_host,
  input wire logic sdio_host_oe,
  input wire logic sdio_dev,
  input wire logic sdio_dev_oe,
  input wire logic sout_dev_oe
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // The device sees the enable through a synchroniser, so it gets a few cycles.
  property p_idle; serial_select_n [*6] |-> !sdio_dev_oe && !sout_dev_oe; endproperty
  a_idle: assert property (p_idle) else $error("pin driven while idle");
  property p_one_pin; !(sdio_dev_oe && sout_dev_oe); endproperty
  a_one_pin: assert property (p_one_pin) else $error("both pins driven");
  property p_no_clash; !(sdio_dev_oe && sdio_host_oe); endproperty
  a_no_clash: assert property (p_no_clash) else $error("data pin clash");
  property p_drive_low; $rose(sdio_dev_oe || sout_dev_oe) |-> !sclk; endproperty
  a_drive_low: assert property (p_drive_low) else $error("drive began high");
  property p_bit_edge; sdio_dev_oe && $past(sdio_dev_oe) && $changed(sdio_dev) |-> !sclk;
  endproperty
  a_bit_edge: assert property (p_bit_edge) else $error("read bit moved high");
  property p_hold; sclk && $past(sclk) && sdio_host_oe |-> $stable(sdio_host); endproperty
  a_hold: assert property (p_hold) else $error("host bit moved high");
  property p_sel_low; sclk |-> !serial_select_n; endproperty
  a_sel_low: assert property (p_sel_low) else $error("clock while deselected");
  property p_setup; $fell(serial_select_n) |-> !sclk [*7]; endproperty
  a_setup: assert property (p_setup) else $error("clock too soon");
endmodule
`default_nettype wire

// ===== testbench/serial_config_port_test.sv
// Bench joining the controller and the configuration port over the serial link.
`timescale 1ns/1ps
`default_nettype none
module serial_config_port_test;
  // Bench drive and design observation.
  logic        clk_i  = 1'b0;
  logic        rstn_i = 1'b0;
  logic        cyc    = 1'b0;
  logic        stb    = 1'b0;
  logic        we     = 1'b0;
  logic [7:0]  adr    = 8'h00;
  logic [31:0] dat    = 32'h0;
  logic [31:0] dout, rdat;
  logic        ack, four, lsb, wstb, sclk_d;
  logic [4:0]  waddr;
  logic [7:0]  wdata, hdr;
  logic [1:0]  seen;        // Pins driven by the device this frame: data pin, output pin.
  logic [12:0] wq[$];       // Finished register writes, address above data.
  int          error_cnt = 0, n_checks = 0, cycles = 0, hcnt = 0;
  always #2.5 clk_i = ~clk_i;
  scp_if link ();
  scp_host i_scp_host (.clk_i, .rstn_i, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(dout), .wb_ack_o(ack),
    .link(link));
  scp_device i_scp_device (.clk_i, .rstn_i, .link(link), .cfg_four_wire_o(four),
    .cfg_lsb_first_o(lsb), .wr_stb_o(wstb), .wr_addr_o(waddr), .wr_data_o(wdata));
  scp_link_props i_scp_link_props (.clk_i, .rstn_i, .sclk(link.sclk),
    .serial_select_n(link.serial_select_n), .sdio_host(link.sdio_host),
    .sdio_host_oe(link.sdio_host_oe), .sdio_dev(link.sdio_dev),
    .sdio_dev_oe(link.sdio_dev_oe), .sout_dev_oe(link.sout_dev_oe));
  task automatic end_of_test();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One classic Wishbone cycle, entered just after a rising edge.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    rdat = dout;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  // Run one transfer to completion and judge the header seen on the wire.
  task automatic xfer(input logic rd, input logic [1:0] n, input logic [4:0] a, input logic l);
    logic [7:0] e;
    e = {<<{{rd, n, a}}};
    if (!l) e = {rd, n, a};
    wb(1'b1, scp_pkg::WB_CTRL, 32'({a, n, rd, 1'b1}));
    rdat = '0;
    for (int i = 0; i < 500 && rdat[1] !== 1'b1; i++) wb(1'b0, scp_pkg::WB_STAT, '0);
    wb(1'b1, scp_pkg::WB_STAT, 32'h2);
    chk("header", 32'(e), 32'(hdr));
  endtask
  task automatic t_wr(input logic l, input logic [1:0] n, input logic [4:0] a,
                      input logic [31:0] d);
    logic [4:0] ea;
    wb(1'b1, scp_pkg::WB_TXD, d);
    wq.delete();
    xfer(1'b0, n, a, l);
    chk("writes", 32'(n) + 1, 32'(wq.size()));
    for (int k = 0; k <= n && k < wq.size(); k++) begin
      ea = l ? a + 5'(k) : a - 5'(k);
      chk("waddr", 32'(ea), 32'(wq[k][12:8]));
      chk("wdata", 32'(d[8*k+:8]), 32'(wq[k][7:0]));
    end
  endtask
  task automatic t_rd(input logic l, input logic f, input logic [1:0] n, input logic [4:0] a,
                      input logic [31:0] x);
    logic [31:0] m;
    m = 32'hffffffff >> (8 * (3 - n));
    xfer(1'b1, n, a, l);
    wb(1'b0, scp_pkg::WB_RXD, '0);
    chk("rxd", x & m, rdat & m);
    chk("pins", f ? 32'h1 : 32'h2, 32'(seen));
  endtask
  // Write the options register, mirror it in the controller and judge the outputs.
  task automatic t_opt(input logic l, input logic [7:0] v);
    t_wr(l, 2'h0, scp_pkg::OPT_ADDR, 32'(v));
    wb(1'b1, scp_pkg::WB_MODE, 32'({v[6], v[7]}));
    chk("options", 32'(v[7:6]), 32'({four, lsb}));
  endtask
  // Header bits in arrival order, pin drivers per frame, finished writes, hang guard.
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    sclk_d <= link.sclk;
    seen   <= (hcnt == 0 && !link.serial_select_n) ? 2'b00
              : seen | {link.sdio_dev_oe, link.sout_dev_oe};
    if (wstb === 1'b1) wq.push_back({waddr, wdata});
    if (link.serial_select_n) hcnt <= 0;
    else if (link.sclk && !sclk_d && hcnt < 8) begin
      hdr  <= {hdr[6:0], link.sdio_line};
      hcnt <= hcnt + 1;
    end
    if (cycles > 20000) begin
      error_cnt++;
      end_of_test();
    end
  end
  initial begin
    repeat (6) @(posedge clk_i);
    rstn_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk("options", 32'h0, 32'({four, lsb}));
    wb(1'b0, 8'h14, 32'h0);
    chk("unmapped", 32'h0, rdat);
    t_wr(1'b0, 2'h2, 5'h05, 32'h332211);
    t_rd(1'b0, 1'b0, 2'h1, 5'h04, 32'h3322);
    t_opt(1'b0, 8'h40);
    t_wr(1'b1, 2'h1, 5'h07, 32'ha55a);
    t_rd(1'b1, 1'b0, 2'h3, 5'h05, 32'ha55a0011);
    t_opt(1'b1, 8'hc0);
    t_rd(1'b1, 1'b1, 2'h0, 5'h04, 32'h22);
    end_of_test();
  end
endmodule
`default_nettype wire
